// ---- test/motor_thermal_overload_limiter_test.sv ----
`timescale 1ns/100ps
`include "olim_defines.svh"
`define OLIM_CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) \
        begin \
            bad_count++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module motor_thermal_overload_limiter_test;
    localparam int T = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] demand = 16'h0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic act;
    logic red;
    logic [15:0] meas;
    logic [15:0] lim;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    olim_top #(.TICK_CYCLES(T)) u_dut (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .meas_current_ma(meas), .applied_current_limit(lim),
        .overload_active(act), .overload_reduced(red));
    olim_motor_model u_motor (.pclk, .demand_ma(demand), .limit_ma(lim),
        .meas_ma(meas));

    always #50 pclk = ~pclk;

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        `OLIM_CHK(nm, ex, rd)
    endtask

    // control written last so settings are complete when it arms
    task automatic cfg(input logic [1:0] c, input logic [15:0] p, r, t);
        apb(1'b1, `OLIM_OFF_PEAK, {16'h0000, p});
        apb(1'b1, `OLIM_OFF_RATED, {16'h0000, r});
        apb(1'b1, `OLIM_OFF_DUR, {16'h0000, t});
        apb(1'b1, `OLIM_OFF_CTRL, {30'h0000_0000, c});
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic wait_red(input logic v);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (red !== v);
    endtask

    task automatic t_regs();
        rchk("ctrl", `OLIM_OFF_CTRL, 32'h0000_0000);
        rchk("status", `OLIM_OFF_STATUS, 32'h0000_0008);
        apb(1'b1, `OLIM_OFF_ACC_LO, 32'hFFFF_FFFF);
        `OLIM_CHK("ro err", 1'b1, err)
        rchk("acc", `OLIM_OFF_ACC_LO, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        `OLIM_CHK("unmapped err", 1'b1, err)
    endtask

    task automatic t_limit();
        cfg(2'h0, 16'h012C, 16'h00C8, 16'h0004);
        rchk("peak", `OLIM_OFF_PEAK, 32'h0000_012C);
        rchk("rated", `OLIM_OFF_RATED, 32'h0000_00C8);
        rchk("dur", `OLIM_OFF_DUR, 32'h0000_0004);
        rchk("lim lo", `OLIM_OFF_LIM_LO, 32'h0003_0D40);
        rchk("lim hi", `OLIM_OFF_LIM_HI, 32'h0000_0000);
        cfg(2'h3, 16'h00C8, 16'h00C8, 16'h0004);
        `OLIM_CHK("equal", 1'b0, act)
        cfg(2'h3, 16'h012C, 16'h00C8, 16'h0000);
        `OLIM_CHK("no time", 1'b0, act)
        cfg(2'h2, 16'h012C, 16'h00C8, 16'h0004);
        `OLIM_CHK("open", 1'b0, act)
        `OLIM_CHK("open cap", 16'h00C8, lim)
        rchk("status", `OLIM_OFF_STATUS, 32'h0000_000C);
        cfg(2'h1, 16'h012C, 16'h00C8, 16'h0004);
        `OLIM_CHK("off", 16'h012C, lim)
    endtask

    task automatic t_run();
        cfg(2'h3, 16'h012C, 16'h00C8, 16'h0004);
        `OLIM_CHK("active", 1'b1, act)
        `OLIM_CHK("start", 16'h012C, lim)
        rchk("status", `OLIM_OFF_STATUS, 32'h0000_000D);
        apb(1'b1, `OLIM_OFF_RCOUNT, 32'h0000_0000);
        rchk("rc clear", `OLIM_OFF_RCOUNT, 32'h0000_0000);
        demand <= 16'h012C;
        wait_red(1'b1);
        `OLIM_CHK("peak t", 1'b1, n > 3 * T && n <= 4 * T + 3)
        `OLIM_CHK("reduced", 16'h00C8, lim)
        rchk("applied", `OLIM_OFF_APPLIED, 32'h0000_00C8);
        rchk("stat red", `OLIM_OFF_STATUS, 32'h0000_000F);
        rchk("rcount", `OLIM_OFF_RCOUNT, 32'h0000_0001);
        rchk("capped", `OLIM_OFF_ACC_LO, 32'h0003_0D40);
        demand <= 16'h0064;
        wait_red(1'b0);
        `OLIM_CHK("back t", 1'b1, n <= T + 3)
        `OLIM_CHK("back", 16'h012C, lim)
        repeat (8 * T) @(posedge pclk);
        rchk("floor", `OLIM_OFF_ACC_LO, 32'h0000_0000);
        demand <= 16'h00FA;
        wait_red(1'b1);
        `OLIM_CHK("small t", 1'b1, n > 8 * T && n <= 9 * T + 3)
        rchk("rcount 2", `OLIM_OFF_RCOUNT, 32'h0000_0002);
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_limit();
        t_run();
        stop_test();
    end
endmodule

// ---- test/olim_motor_model.sv ----
`timescale 1ns/100ps
module olim_motor_model
(
    // clock
    input wire logic pclk,
    // demand and applied limit
    input wire logic [15:0] demand_ma,
    input wire logic [15:0] limit_ma,
    // sensed winding current
    output logic [15:0] meas_ma
);
    // regulator clamps to the limit, current settles one cycle late
    always_ff @(posedge pclk)
        meas_ma <= (demand_ma < limit_ma) ? demand_ma : limit_ma;
endmodule

// ---- test/olim_top_checker.sv ----
`timescale 1ns/100ps
`include "olim_defines.svh"
module olim_top_checker
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // regulator side
    input wire logic [15:0] applied_current_limit,
    input wire logic overload_active,
    input wire logic overload_reduced
);
    logic [1:0] ctrl_q;
    logic [15:0] peak_q;
    logic [15:0] rated_q;
    logic [15:0] dur_q;
    logic armed;
    logic go;

    // shadow of the writable settings
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ctrl_q <= 2'h0;
            peak_q <= 16'h0000;
            rated_q <= 16'h0000;
            dur_q <= 16'h0000;
        end
        else if (psel && penable && pwrite && pready)
        begin
            case (paddr)
                `OLIM_OFF_CTRL: ctrl_q <= pwdata[1:0];
                `OLIM_OFF_PEAK: peak_q <= pwdata[15:0];
                `OLIM_OFF_RATED: rated_q <= pwdata[15:0];
                `OLIM_OFF_DUR: dur_q <= pwdata[15:0];
                default: ;
            endcase
        end

    assign armed = ctrl_q[1] && (peak_q > rated_q) && (dur_q != 16'h0000);
    assign go = armed && ctrl_q[0];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    active_cond_a: assert property (
        overload_active == $past(go))
        else $error("active flag disagrees with settings");
    open_cap_a: assert property ((armed && !ctrl_q[0])[*3]
        |-> applied_current_limit == $past(rated_q))
        else $error("open loop cap");
    idle_peak_a: assert property ((!armed)[*3]
        |-> applied_current_limit == $past(peak_q))
        else $error("idle limit");
    level_pick_a: assert property (go[*3] |-> applied_current_limit ==
        (overload_reduced ? $past(rated_q) : $past(peak_q)))
        else $error("level pick");
    quiet_gate_a: assert property (!overload_active &&
        !$past(overload_active) |-> !overload_reduced) else $error("gate");
    reset_quiet_a: assert property ($rose(presetn) |->
        !overload_reduced && applied_current_limit == 16'h0000)
        else $error("state after reset");
    restore_peak_a: assert property (go && $fell(overload_reduced)
        && $past(go) |-> applied_current_limit == $past(peak_q))
        else $error("restore");
    reduce_rated_a: assert property (go && $rose(overload_reduced)
        |-> applied_current_limit == $past(rated_q)) else $error("reduce");

    cover property (go && $rose(overload_reduced));
    cover property (go && $fell(overload_reduced));
    cover property (armed && !ctrl_q[0]);
endmodule

bind olim_top olim_top_checker u_chk (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .applied_current_limit,
    .overload_active, .overload_reduced);

// ---- verilog/olim_cfg_if.sv ----
`timescale 1ns/100ps
interface olim_cfg_if;
    olim_pkg::olim_ma_t peak;
    olim_pkg::olim_ma_t rated;
    olim_pkg::olim_ms_t dur;
    olim_pkg::olim_energy_t limit;
    logic limit_valid;

    modport calc
    (
        input peak,
        input rated,
        input dur,
        output limit,
        output limit_valid
    );

    modport core
    (
        output peak,
        output rated,
        output dur,
        input limit,
        input limit_valid
    );
endinterface

// ---- verilog/olim_defines.svh ----
`ifndef OLIM_DEFINES_SVH
`define OLIM_DEFINES_SVH

// register byte offsets on the apb bus
`define OLIM_OFF_CTRL 8'h00
`define OLIM_OFF_PEAK 8'h04
`define OLIM_OFF_RATED 8'h08
`define OLIM_OFF_DUR 8'h0C
`define OLIM_OFF_LIM_LO 8'h10
`define OLIM_OFF_LIM_HI 8'h14
`define OLIM_OFF_ACC_LO 8'h18
`define OLIM_OFF_ACC_HI 8'h1C
`define OLIM_OFF_APPLIED 8'h20
`define OLIM_OFF_STATUS 8'h24
`define OLIM_OFF_RCOUNT 8'h28

// control and status bit positions
`define OLIM_CTRL_CLOSED 0
`define OLIM_CTRL_EN 1
`define OLIM_STAT_ACTIVE 0
`define OLIM_STAT_REDUCED 1
`define OLIM_STAT_ARMED 2
`define OLIM_STAT_VALID 3

// reset values and counter constants
`define OLIM_CTRL_RST 2'h0
`define OLIM_MA_RST 16'h0000
`define OLIM_DUR_RST 16'h0000
`define OLIM_ACC_RST 48'h0000_0000_0000
`define OLIM_CNT_RST 16'h0000
`define OLIM_CNT_ONE 16'h0001
`define OLIM_CNT_MAX 16'hFFFF

// timing: accumulation step of one millisecond
`define OLIM_TICK_NS 1000000
`define OLIM_CLK_NS 100

`endif

// ---- verilog/olim_limit_calc.sv ----
`timescale 1ns/100ps
`include "olim_defines.svh"
module olim_limit_calc
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // settings in, limit out
    olim_cfg_if.calc cfg
);
    olim_pkg::olim_sq_t diff_q;
    olim_pkg::olim_ms_t dur_q;
    logic [47:0] tag1_q;
    logic [47:0] tag2_q;
    olim_pkg::olim_energy_t limit_q;
    logic [47:0] tag_now;

    assign tag_now = {cfg.peak, cfg.rated, cfg.dur};

    // two stages keep the wide multiply off the bus path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            diff_q <= 32'h0000_0000;
            dur_q <= `OLIM_DUR_RST;
            tag1_q <= 48'h0000_0000_0000;
        end
        else
        begin
            diff_q <= (cfg.peak > cfg.rated) ?
                olim_pkg::olim_sq(cfg.peak) - olim_pkg::olim_sq(cfg.rated) :
                32'h0000_0000;
            dur_q <= cfg.dur;
            tag1_q <= tag_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            limit_q <= `OLIM_ACC_RST;
            tag2_q <= 48'hFFFF_FFFF_FFFF;
        end
        else
        begin
            limit_q <= 48'(diff_q) * 48'(dur_q);
            tag2_q <= tag1_q;
        end
    end

    assign cfg.limit = limit_q;
    // stale while a settings change ripples through
    assign cfg.limit_valid = (tag2_q == tag_now);
endmodule

// ---- verilog/olim_pkg.sv ----
package olim_pkg;

    // currents in milliamperes, duration in milliseconds
    typedef logic [15:0] olim_ma_t;
    typedef logic [15:0] olim_ms_t;
    typedef logic [31:0] olim_sq_t;
    // energy in mA*mA*ms
    typedef logic [47:0] olim_energy_t;

    function automatic olim_sq_t olim_sq(input olim_ma_t x);
        olim_sq_t r;
        r = olim_sq_t'(x) * olim_sq_t'(x);
        return r;
    endfunction

endpackage

// ---- verilog/olim_tick.sv ----
`timescale 1ns/100ps
module olim_tick #(
    parameter int unsigned TICK_CYCLES = 10000
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // step strobe
    output logic tick
);
    logic [31:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 32'h0000_0000;
        else if (cnt_q == 32'(TICK_CYCLES - 1))
            cnt_q <= 32'h0000_0000;
        else
            cnt_q <= cnt_q + 32'h0000_0001;
    end

    assign tick = (cnt_q == 32'(TICK_CYCLES - 1));
endmodule

// ---- verilog/olim_top.sv ----
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "olim_defines.svh"
module olim_top #(
    parameter int unsigned TICK_CYCLES = `OLIM_TICK_NS / `OLIM_CLK_NS
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // current regulator side
    input wire logic [15:0] meas_current_ma,
    output logic [15:0] applied_current_limit,
    output logic overload_active,
    output logic overload_reduced
);
    olim_cfg_if cfg_bus();

    logic [1:0] ctrl_q;
    olim_pkg::olim_ma_t peak_q;
    olim_pkg::olim_ma_t rated_q;
    olim_pkg::olim_ms_t dur_q;
    olim_pkg::olim_ma_t meas_q;
    olim_pkg::olim_energy_t acc_q;
    olim_pkg::olim_energy_t acc_d;
    olim_pkg::olim_ma_t applied_q;
    olim_pkg::olim_ma_t applied_d;
    logic reduced_q;
    logic active_q;
    logic [15:0] rcount_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic tick;
    logic setup_ph;
    logic wr_acc;
    logic wr_ctrl;
    logic wr_peak;
    logic wr_rated;
    logic wr_dur;
    logic wr_rcount;
    logic cfg_ok;
    logic armed;
    logic active;
    logic reduced_now;
    logic rd_hit;
    logic rd_ro;
    logic [31:0] rd_data;

    olim_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    )
    u_tick
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    olim_limit_calc u_calc
    (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_bus.calc)
    );

    assign cfg_bus.peak = peak_q;
    assign cfg_bus.rated = rated_q;
    assign cfg_bus.dur = dur_q;

    // one write strobe per writable register word
    function automatic logic wr_to(
        input logic acc,
        input logic [7:0] addr,
        input logic [7:0] off
    );
        return acc && (addr == off);
    endfunction

    // bus phases
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite && !pslverr_q;
    // zero wait states: every access ends in its second cycle
    assign pready = 1'b1;
    assign wr_ctrl = wr_to(wr_acc, paddr, `OLIM_OFF_CTRL);
    assign wr_peak = wr_to(wr_acc, paddr, `OLIM_OFF_PEAK);
    assign wr_rated = wr_to(wr_acc, paddr, `OLIM_OFF_RATED);
    assign wr_dur = wr_to(wr_acc, paddr, `OLIM_OFF_DUR);
    assign wr_rcount = wr_to(wr_acc, paddr, `OLIM_OFF_RCOUNT);

    // settings written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `OLIM_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            peak_q <= `OLIM_MA_RST;
        else if (wr_peak)
            peak_q <= pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rated_q <= `OLIM_MA_RST;
        else if (wr_rated)
            rated_q <= pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dur_q <= `OLIM_DUR_RST;
        else if (wr_dur)
            dur_q <= pwdata[15:0];
    end

    // activation
    assign cfg_ok = (peak_q > rated_q) && (dur_q != 16'h0000);
    assign armed = ctrl_q[`OLIM_CTRL_EN] && cfg_ok;
    assign active = armed && ctrl_q[`OLIM_CTRL_CLOSED];

    // measured current sampled once per clock for a steady step value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            meas_q <= `OLIM_MA_RST;
        else
            meas_q <= meas_current_ma;
    end

    // distance between two squared currents, larger current first
    function automatic olim_pkg::olim_energy_t sq_gap(
        input olim_pkg::olim_ma_t hi_ma,
        input olim_pkg::olim_ma_t lo_ma
    );
        return 48'(olim_pkg::olim_sq(hi_ma) - olim_pkg::olim_sq(lo_ma));
    endfunction

    // accumulation in mA*mA*ms, one step per millisecond
    always_comb
    begin
        logic [48:0] sum;
        sum = 49'h0_0000_0000_0000;
        acc_d = acc_q;
        if (!active)
            acc_d = `OLIM_ACC_RST;
        else if (tick && meas_q > rated_q)
        begin
            // square law: full peak climbs fastest
            sum = 49'(acc_q) + 49'(sq_gap(meas_q, rated_q));
            // capped so recovery starts right at the threshold
            if (cfg_bus.limit_valid && sum > 49'(cfg_bus.limit))
                acc_d = cfg_bus.limit;
            else
                acc_d = sum[47:0];
        end
        else if (tick && meas_q < rated_q)
        begin
            if (sq_gap(rated_q, meas_q) >= acc_q)
                acc_d = `OLIM_ACC_RST;
            else
                acc_d = acc_q - sq_gap(rated_q, meas_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= `OLIM_ACC_RST;
        else
            acc_q <= acc_d;
    end

    // a stale threshold is treated as reached: safe side while it settles
    assign reduced_now = !cfg_bus.limit_valid ||
        (acc_d >= cfg_bus.limit);

    // applied limit follows the next accumulator value with no extra lag
    always_comb
    begin
        applied_d = peak_q;
        if (armed && !ctrl_q[`OLIM_CTRL_CLOSED])
            applied_d = rated_q;
        else if (active && reduced_now)
            applied_d = rated_q;
        else if (active)
            applied_d = peak_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            applied_q <= `OLIM_MA_RST;
        else
            applied_q <= applied_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reduced_q <= 1'b0;
        else
            reduced_q <= active && reduced_now;
    end

    // reduction events; a new one beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rcount_q <= `OLIM_CNT_RST;
        else if (active && reduced_now && !reduced_q)
        begin
            if (wr_rcount)
                rcount_q <= `OLIM_CNT_ONE;
            else if (rcount_q != `OLIM_CNT_MAX)
                rcount_q <= rcount_q + `OLIM_CNT_ONE;
        end
        else if (wr_rcount)
            rcount_q <= `OLIM_CNT_RST;
    end

    // registered so the regulator sees a settled level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_q <= 1'b0;
        else
            active_q <= active;
    end

    assign applied_current_limit = applied_q;
    assign overload_active = active_q;
    assign overload_reduced = reduced_q;

    // read decode
    // limitation: wide words are not snapshotted, lo and hi may tear
    always_comb
    begin
        rd_hit = 1'b1;
        rd_ro = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (paddr)
            `OLIM_OFF_CTRL:
            begin
                rd_data = {30'h0000_0000, ctrl_q};
                rd_ro = 1'b0;
            end
            `OLIM_OFF_PEAK:
            begin
                rd_data = {16'h0000, peak_q};
                rd_ro = 1'b0;
            end
            `OLIM_OFF_RATED:
            begin
                rd_data = {16'h0000, rated_q};
                rd_ro = 1'b0;
            end
            `OLIM_OFF_DUR:
            begin
                rd_data = {16'h0000, dur_q};
                rd_ro = 1'b0;
            end
            `OLIM_OFF_LIM_LO:
                rd_data = cfg_bus.limit[31:0];
            `OLIM_OFF_LIM_HI:
                rd_data = {16'h0000, cfg_bus.limit[47:32]};
            `OLIM_OFF_ACC_LO:
                rd_data = acc_q[31:0];
            `OLIM_OFF_ACC_HI:
                rd_data = {16'h0000, acc_q[47:32]};
            `OLIM_OFF_APPLIED:
                rd_data = {16'h0000, applied_q};
            `OLIM_OFF_STATUS:
            begin
                rd_data[`OLIM_STAT_ACTIVE] = active;
                rd_data[`OLIM_STAT_REDUCED] = reduced_q;
                rd_data[`OLIM_STAT_ARMED] = armed;
                rd_data[`OLIM_STAT_VALID] = cfg_bus.limit_valid;
            end
            `OLIM_OFF_RCOUNT:
            begin
                rd_data = {16'h0000, rcount_q};
                rd_ro = 1'b0;
            end
            default:
                rd_hit = 1'b0;
        endcase
    end

    // answer captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup_ph)
            prdata_q <= (rd_hit && !pwrite) ? rd_data : 32'h0000_0000;
    end

    // unmapped address or write to a read-only word is refused
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_q <= 1'b0;
        else if (setup_ph)
            pslverr_q <= !rd_hit || (pwrite && rd_ro);
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;
endmodule
